/* File: core/aec_consts.svh */
// Purpose: offsets, bit positions and reset values of the event counter
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: definitions only
`ifndef AEC_CONSTS_SVH
`define AEC_CONSTS_SVH
`define AEC_IDX_PER_H 16'hFF8C
`define AEC_IDX_PER_L 16'hFF8D
`define AEC_IDX_DAT_H 16'hFF8E
`define AEC_IDX_DAT_L 16'hFF8F
`define AEC_IDX_EGS 16'hFF92
`define AEC_IDX_CCR 16'hFF94
`define AEC_IDX_CSR 16'hFF95
`define AEC_IDX_CNT_H 16'hFF96
`define AEC_IDX_CNT_L 16'hFF97
`define AEC_IDX_STP 16'hFFFB
`define AEC_EGS_H_LSB 6
`define AEC_EGS_L_LSB 4
`define AEC_EGS_G_LSB 2
`define AEC_EGS_PWME 1
`define AEC_CCR_H_LSB 6
`define AEC_CCR_L_LSB 4
`define AEC_CCR_PW_LSB 1
`define AEC_CSR_OVH 7
`define AEC_CSR_OVL 6
`define AEC_CSR_CH2 4
`define AEC_CSR_CUEH 3
`define AEC_CSR_CUEL 2
`define AEC_CSR_CRCH 1
`define AEC_CSR_CRCL 0
`define AEC_STP_BIT 3
`define AEC_RST_PER 8'hFF
`define AEC_RST_ZERO 8'h00
`define AEC_RST_STP 8'hFF
`endif

/* File: core/aec_pkg.sv */
// Purpose: types of the event counter
// Assumes: nothing
// Notes: whole state of the top is one packed struct
package aec_pkg;
    typedef struct packed {
        logic [2:0]  hs;
        logic [2:0]  ls;
        logic [2:0]  gs;
        logic        gprev;
        logic [5:0]  pr;
        logic [15:0] pcnt;
        logic        pwm;
        logic [7:0]  per_h;
        logic [7:0]  per_l;
        logic [7:0]  dat_h;
        logic [7:0]  dat_l;
        logic [7:0]  egs;
        logic [7:0]  ccr;
        logic [7:0]  csr;
        logic [7:0]  cnt_h;
        logic [7:0]  cnt_l;
        logic [7:0]  stp;
        logic        seen_h;
        logic        seen_l;
        logic [31:0] rdata;
        logic        rdy;
        logic        err;
        logic        ovf;
        logic        girq;
    } aec_st_t;
endpackage

/* File: core/aec_top.sv */
// Purpose: event counter with gating pwm behind an APB slave
// Assumes: pins are synchronised to pclk (10 MHz)
// Notes: counting is sampled on pclk, not truly clockless
// How it works
// - Count external events regardless of base clocks
// - One 16-bit channel counting 65536 events
// - Or two independent 8-bit channels
// - Count only while gate signal is high
// - Gate edges raise interrupt, also standalone
// - Gating pwm toggles counting periodically
// - Clock source: pin or phi/2,/4,/8
// - Software resets and halts counters
// - Counter overflow raises interrupt
// - Clock stop bit puts block in standby
// - Two period registers, reset all ones
// - Two write-only data registers, reset zero
// - High pin edge: fall, rise, both
// - Edge select register, eight bits, reset zero
// - Pwm enable picks pwm or gate pin
// - Split bit clear cascades low into high
// - High overflow flag, read-then-write-zero clear
`include "aec_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module aec_top
    import aec_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        high_event_pin,
    input  wire logic        low_event_pin,
    input  wire logic        gate_interrupt_pin,
    output logic             gating_pwm_output,
    output logic             overflow_irq,
    output logic             gate_irq
);
    aec_st_t s;
    aec_st_t n;
    logic [15:0] idx;
    logic        acc;
    logic        wr;
    logic        gate;
    logic        run;
    logic        pwme;
    logic        ch2;
    logic        ev_h;
    logic        ev_l;
    logic        inc_h;
    logic        inc_l;
    logic        lo_wrap;
    logic        hi_wrap;
    logic        pw_tick;
    logic        g_edge;
    logic [31:0] rd;
    logic        hit;

    function automatic logic edge_of(input logic [1:0] sel,
                                     input logic cur,
                                     input logic prv);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'b00: r = prv & ~cur;
            2'b01: r = cur & ~prv;
            2'b10: r = cur ^ prv;
            2'b11: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic div_tick(input logic [5:0] pr,
                                      input int unsigned k);
        logic [5:0] m;
        m = 6'(({6'h0, 1'b1} << k) - 7'h01);
        return (pr & m) == m;
    endfunction

    function automatic logic src_ev(input logic [1:0] sel,
                                    input logic pin_ev,
                                    input logic [5:0] pr);
        logic r;
        r = pin_ev;
        unique case (sel)
            2'b00: r = pin_ev;
            2'b01: r = div_tick(pr, 1);
            2'b10: r = div_tick(pr, 2);
            2'b11: r = div_tick(pr, 3);
        endcase
        return r;
    endfunction

    assign idx = paddr[17:2];
    assign acc = psel & penable & s.rdy;
    assign wr = acc & pwrite;
    assign pwme = s.egs[`AEC_EGS_PWME];
    assign ch2 = s.csr[`AEC_CSR_CH2];
    assign run = s.stp[`AEC_STP_BIT];
    assign gate = pwme ? s.pwm : s.gs[1];

    // Pwm clock: phi/2 up to phi/64
    always_comb begin
        pw_tick = div_tick(s.pr, 1);
        unique case (s.ccr[`AEC_CCR_PW_LSB +: 3])
            3'b000: pw_tick = div_tick(s.pr, 1);
            3'b001: pw_tick = div_tick(s.pr, 2);
            3'b010: pw_tick = div_tick(s.pr, 3);
            3'b011: pw_tick = div_tick(s.pr, 4);
            3'b100,
            3'b110: pw_tick = div_tick(s.pr, 5);
            3'b101,
            3'b111: pw_tick = div_tick(s.pr, 6);
        endcase
    end

    // Pin or prescaler event per channel
    assign ev_h = src_ev(s.ccr[`AEC_CCR_H_LSB +: 2],
                         edge_of(s.egs[`AEC_EGS_H_LSB +: 2], s.hs[1], s.hs[2]),
                         s.pr);
    assign ev_l = src_ev(s.ccr[`AEC_CCR_L_LSB +: 2],
                         edge_of(s.egs[`AEC_EGS_L_LSB +: 2], s.ls[1], s.ls[2]),
                         s.pr);
    assign inc_l = ev_l & gate & run
                   & s.csr[`AEC_CSR_CUEL] & s.csr[`AEC_CSR_CRCL];
    assign lo_wrap = inc_l & (s.cnt_l == 8'hFF);
    assign inc_h = (ch2 ? (ev_h & gate) : lo_wrap)
                   & run & s.csr[`AEC_CSR_CUEH] & s.csr[`AEC_CSR_CRCH];
    assign hi_wrap = inc_h & (s.cnt_h == 8'hFF);
    assign g_edge = edge_of(s.egs[`AEC_EGS_G_LSB +: 2], gate, s.gprev);

    always_comb begin
        hit = 1'b1;
        rd = 32'h0000_0000;
        unique case (idx)
            `AEC_IDX_PER_H: rd[7:0] = s.per_h;
            `AEC_IDX_PER_L: rd[7:0] = s.per_l;
            `AEC_IDX_DAT_H: rd[7:0] = 8'h00;
            `AEC_IDX_DAT_L: rd[7:0] = 8'h00;
            `AEC_IDX_EGS: rd[7:0] = s.egs;
            `AEC_IDX_CCR: rd[7:0] = s.ccr;
            `AEC_IDX_CSR: rd[7:0] = s.csr;
            `AEC_IDX_CNT_H: rd[7:0] = s.cnt_h;
            `AEC_IDX_CNT_L: rd[7:0] = s.cnt_l;
            `AEC_IDX_STP: rd[7:0] = s.stp;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        n = s;
        // Second stage feeds logic; third stage is the previous value for event edges
        n.hs = {s.hs[1], s.hs[0], high_event_pin};
        n.ls = {s.ls[1], s.ls[0], low_event_pin};
        n.gs = {s.gs[1], s.gs[0], gate_interrupt_pin};
        n.gprev = gate;
        n.pr = s.pr + 6'h01;
        n.girq = g_edge;
        // Gating pwm waveform
        if (!pwme || !run) begin
            n.pcnt = 16'h0000;
            n.pwm = 1'b0;
        end else if (pw_tick) begin
            n.pcnt = (s.pcnt >= {s.per_h, s.per_l}) ? 16'h0000
                                                   : s.pcnt + 16'h0001;
            n.pwm = s.pcnt < {s.dat_h, s.dat_l};
        end
        // Counters
        if (!s.csr[`AEC_CSR_CRCL]) begin
            n.cnt_l = 8'h00;
        end else if (inc_l) begin
            n.cnt_l = s.cnt_l + 8'h01;
        end
        if (!s.csr[`AEC_CSR_CRCH]) begin
            n.cnt_h = 8'h00;
        end else if (inc_h) begin
            n.cnt_h = s.cnt_h + 8'h01;
        end
        // Bus
        n.rdy = psel & ~penable & ~s.rdy;
        if (psel && !penable) begin
            n.rdata = rd;
            n.err = ~hit;
        end
        if (acc && !pwrite && idx == `AEC_IDX_CSR) begin
            n.seen_h = s.csr[`AEC_CSR_OVH];
            n.seen_l = s.csr[`AEC_CSR_OVL];
        end
        if (wr) begin
            unique case (idx)
                `AEC_IDX_PER_H: n.per_h = pwdata[7:0];
                `AEC_IDX_PER_L: n.per_l = pwdata[7:0];
                `AEC_IDX_DAT_H: n.dat_h = pwdata[7:0];
                `AEC_IDX_DAT_L: n.dat_l = pwdata[7:0];
                `AEC_IDX_EGS: n.egs = pwdata[7:0];
                `AEC_IDX_CCR: n.ccr = pwdata[7:0];
                `AEC_IDX_STP: n.stp = pwdata[7:0];
                `AEC_IDX_CSR: begin
                    n.csr[5:0] = pwdata[5:0];
                    if (!pwdata[`AEC_CSR_OVH] && s.seen_h) begin
                        n.csr[`AEC_CSR_OVH] = 1'b0;
                        n.seen_h = 1'b0;
                    end
                    if (!pwdata[`AEC_CSR_OVL] && s.seen_l) begin
                        n.csr[`AEC_CSR_OVL] = 1'b0;
                        n.seen_l = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Set wins over clear
        if (hi_wrap) begin
            n.csr[`AEC_CSR_OVH] = 1'b1;
        end
        if (lo_wrap) begin
            n.csr[`AEC_CSR_OVL] = 1'b1;
        end
        n.ovf = n.csr[`AEC_CSR_OVH] | n.csr[`AEC_CSR_OVL];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.per_h <= `AEC_RST_PER;
            s.per_l <= `AEC_RST_PER;
            s.dat_h <= `AEC_RST_ZERO;
            s.dat_l <= `AEC_RST_ZERO;
            s.egs <= `AEC_RST_ZERO;
            s.ccr <= `AEC_RST_ZERO;
            s.csr <= `AEC_RST_ZERO;
            s.stp <= `AEC_RST_STP;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.rdy;
    assign pslverr = s.err;
    assign gating_pwm_output = s.pwm;
    assign overflow_irq = s.ovf;
    assign gate_irq = s.girq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable && !s.rdy;
    endsequence
    sequence ovh_read_s;
        acc && !pwrite && idx == `AEC_IDX_CSR && s.csr[`AEC_CSR_OVH];
    endsequence

    apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    crc_clear_a: assert property (!s.csr[`AEC_CSR_CRCL] |=> s.cnt_l == 8'h00)
        else $error("low counter not held at zero");
    halt_low_a: assert property (!s.csr[`AEC_CSR_CUEL] |=> $stable(s.cnt_l) || s.cnt_l == 8'h00)
        else $error("low counter moved while halted");
    gate_block_a: assert property (!gate && s.csr[`AEC_CSR_CRCL] |=> $stable(s.cnt_l))
        else $error("low counter moved with gate low");
    standby_hold_a: assert property (!run |=> $stable(s.cnt_h) || s.cnt_h == 8'h00)
        else $error("high counter moved in standby");
    low_wrap_a: assert property (lo_wrap |=> s.csr[`AEC_CSR_OVL] && overflow_irq)
        else $error("low overflow not flagged");
    cascade_step_a: assert property (!ch2 && inc_h |=> s.cnt_h == $past(s.cnt_h) + 8'h01)
        else $error("cascade did not step high counter");
    casc_src_a: assert property (!ch2 && inc_h |-> lo_wrap)
        else $error("high counter stepped without low wrap");
    high_wrap_a: assert property (hi_wrap |=> s.csr[`AEC_CSR_OVH] && s.cnt_h == 8'h00)
        else $error("high wrap not flagged");
    ovh_clear_a: assert property (ovh_read_s ##[1:50] (wr && idx == `AEC_IDX_CSR
                                  && !pwdata[`AEC_CSR_OVH] && !hi_wrap)
                                  |=> !s.csr[`AEC_CSR_OVH])
        else $error("flag not cleared after read then zero");
    ovh_keep_a: assert property (wr && idx == `AEC_IDX_CSR && !s.seen_h
                                 && s.csr[`AEC_CSR_OVH] |=> s.csr[`AEC_CSR_OVH])
        else $error("flag cleared without prior read");
    pwm_off_a: assert property (!pwme |=> !gating_pwm_output)
        else $error("pwm output high while disabled");
    gate_irq_a: assert property (g_edge |=> gate_irq)
        else $error("gate edge missed");
endmodule
`default_nettype wire

/* File: testbench/aec_pins_model.sv */
// Purpose: event pin and gate pin source for the event counter
// Assumes: pins change just after a pclk rising edge
// Notes: pulses stay 3 cycles high and 4 low, above the sync limit
`timescale 1ns/1ps
`default_nettype none
module aec_pins_model (
    input  wire logic pclk,
    output logic      high_event_pin,
    output logic      low_event_pin,
    output logic      gate_interrupt_pin
);
    initial begin
        high_event_pin = 1'b0;
        low_event_pin = 1'b0;
        gate_interrupt_pin = 1'b0;
    end
    task automatic pulses(input logic hi, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (hi) high_event_pin <= 1'b1;
            else low_event_pin <= 1'b1;
            repeat (3) @(posedge pclk);
            high_event_pin <= 1'b0;
            low_event_pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
    task automatic gate(input logic v);
        @(posedge pclk);
        gate_interrupt_pin <= v;
        repeat (5) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* File: testbench/aec_top_bench.sv */
// Purpose: self-checking bench of the event counter
// Assumes: APB answers in its own time; pins come from the pin model
// Notes: prescaled counts are judged within a small window
`include "aec_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define AEC_CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
    end \
end
module aec_top_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wire         hpin;
    wire         lpin;
    wire         gpin;
    logic        gating_pwm_output;
    logic        overflow_irq;
    logic        gate_irq;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          compares = 0;
    int          girqs = 0;

    aec_top aec_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_event_pin(hpin), .low_event_pin(lpin),
        .gate_interrupt_pin(gpin), .gating_pwm_output(gating_pwm_output),
        .overflow_irq(overflow_irq), .gate_irq(gate_irq));
    aec_pins_model aec_pins_model_i (.pclk(pclk), .high_event_pin(hpin),
        .low_event_pin(lpin), .gate_interrupt_pin(gpin));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (gate_irq === 1'b1) girqs <= girqs + 1;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'hA5C3E1, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) mismatches++;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `AEC_CHK(rd[7:0], e)
    endtask
    task automatic t_reset();
        rdc(`AEC_IDX_PER_H, 8'hFF);
        rdc(`AEC_IDX_PER_L, 8'hFF);
        rdc(`AEC_IDX_EGS, 8'h00);
        rdc(`AEC_IDX_CCR, 8'h00);
        rdc(`AEC_IDX_CSR, 8'h00);
        rdc(`AEC_IDX_CNT_L, 8'h00);
        rdc(`AEC_IDX_STP, 8'hFF);
        wr(`AEC_IDX_CNT_H, 8'h55);
        rdc(`AEC_IDX_CNT_H, 8'h00);
        wr(`AEC_IDX_EGS, 8'hA4);
        rdc(`AEC_IDX_EGS, 8'hA4);
        wr(`AEC_IDX_EGS, 8'h00);
        apb(1'b0, 16'hFF90, 8'h00);
        `AEC_CHK(err, 1'b1)
        `AEC_CHK(rd, 32'h00000000)
    endtask
    task automatic t_edges();
        int eh[4] = '{3, 3, 6, 0};
        aec_pins_model_i.gate(1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(`AEC_IDX_EGS, 8'(m * 64));
            wr(`AEC_IDX_CSR, 8'h10);
            wr(`AEC_IDX_CSR, 8'h1A);
            aec_pins_model_i.pulses(1'b1, 3);
            rdc(`AEC_IDX_CNT_H, 8'(eh[m]));
        end
        wr(`AEC_IDX_EGS, 8'h00);
        wr(`AEC_IDX_CSR, 8'h10);
        wr(`AEC_IDX_CSR, 8'h1F);
        aec_pins_model_i.pulses(1'b1, 2);
        aec_pins_model_i.pulses(1'b0, 5);
        rdc(`AEC_IDX_CNT_H, 8'h02);
        rdc(`AEC_IDX_CNT_L, 8'h05);
        aec_pins_model_i.gate(1'b0);
        wr(`AEC_IDX_CSR, 8'h10);
        wr(`AEC_IDX_CSR, 8'h1A);
        aec_pins_model_i.pulses(1'b1, 2);
        rdc(`AEC_IDX_CNT_H, 8'h00);
    endtask
    task automatic t_ovf();
        logic [7:0] v;
        aec_pins_model_i.gate(1'b1);
        wr(`AEC_IDX_CSR, 8'h00);
        wr(`AEC_IDX_CSR, 8'h0F);
        aec_pins_model_i.pulses(1'b0, 256);
        rdc(`AEC_IDX_CNT_L, 8'h00);
        rdc(`AEC_IDX_CNT_H, 8'h01);
        `AEC_CHK(overflow_irq, 1'b1)
        rdc(`AEC_IDX_CSR, 8'h4F);
        wr(`AEC_IDX_CSR, 8'h0F);
        rdc(`AEC_IDX_CSR, 8'h0F);
        wr(`AEC_IDX_CSR, 8'hCF);
        rdc(`AEC_IDX_CSR, 8'h0F);
        wr(`AEC_IDX_CCR, 8'h40);
        wr(`AEC_IDX_CSR, 8'h1A);
        repeat (560) @(posedge pclk);
        wr(`AEC_IDX_CSR, 8'h12);
        wr(`AEC_IDX_CSR, 8'h12);
        rdc(`AEC_IDX_CSR, 8'h92);
        apb(1'b0, `AEC_IDX_CNT_H, 8'h00);
        v = rd[7:0];
        repeat (40) @(posedge pclk);
        rdc(`AEC_IDX_CNT_H, v);
        wr(`AEC_IDX_CSR, 8'h12);
        rdc(`AEC_IDX_CSR, 8'h12);
        `AEC_CHK(overflow_irq, 1'b0)
    endtask
    task automatic t_pre();
        int e;
        for (int s = 1; s < 4; s++) begin
            e = 80 >> s;
            wr(`AEC_IDX_CSR, 8'h10);
            wr(`AEC_IDX_CCR, 8'(s * 64));
            wr(`AEC_IDX_CSR, 8'h1A);
            repeat (80) @(posedge pclk);
            wr(`AEC_IDX_CSR, 8'h12);
            apb(1'b0, `AEC_IDX_CNT_H, 8'h00);
            `AEC_CHK(rd >= e - 1 && rd <= e + 2, 1'b1)
        end
    endtask
    task automatic pwm_watch(input int n, output int hi);
        hi = 0;
        repeat (n) begin
            @(posedge pclk);
            if (gating_pwm_output === 1'b1) hi++;
        end
    endtask
    task automatic t_pwm();
        int hi;
        wr(`AEC_IDX_PER_H, 8'h00);
        wr(`AEC_IDX_PER_L, 8'h03);
        wr(`AEC_IDX_CCR, 8'h10);
        wr(`AEC_IDX_EGS, 8'h02);
        pwm_watch(40, hi);
        `AEC_CHK(hi, 0)
        wr(`AEC_IDX_EGS, 8'h00);
        wr(`AEC_IDX_DAT_H, 8'h00);
        wr(`AEC_IDX_DAT_L, 8'h02);
        aec_pins_model_i.gate(1'b0);
        wr(`AEC_IDX_CSR, 8'h10);
        wr(`AEC_IDX_CSR, 8'h15);
        wr(`AEC_IDX_EGS, 8'h02);
        pwm_watch(400, hi);
        wr(`AEC_IDX_CSR, 8'h11);
        wr(`AEC_IDX_EGS, 8'h00);
        `AEC_CHK(hi >= 190 && hi <= 210, 1'b1)
        apb(1'b0, `AEC_IDX_CNT_L, 8'h00);
        `AEC_CHK(rd >= 85 && rd <= 115, 1'b1)
    endtask
    task automatic t_girq();
        int g0;
        int eg[3] = '{1, 1, 2};
        for (int m = 0; m < 3; m++) begin
            wr(`AEC_IDX_EGS, 8'(m * 4));
            g0 = girqs;
            aec_pins_model_i.gate(1'b1);
            aec_pins_model_i.gate(1'b0);
            `AEC_CHK(girqs - g0, eg[m])
        end
    endtask
    task automatic t_stby();
        wr(`AEC_IDX_CCR, 8'h00);
        aec_pins_model_i.gate(1'b1);
        wr(`AEC_IDX_CSR, 8'h10);
        wr(`AEC_IDX_CSR, 8'h1A);
        wr(`AEC_IDX_STP, 8'hF7);
        aec_pins_model_i.pulses(1'b1, 2);
        rdc(`AEC_IDX_CNT_H, 8'h00);
        wr(`AEC_IDX_STP, 8'hFF);
        aec_pins_model_i.pulses(1'b1, 2);
        rdc(`AEC_IDX_CNT_H, 8'h02);
    endtask

    task automatic t_rst2();
        wr(`AEC_IDX_PER_H, 8'h12);
        wr(`AEC_IDX_CCR, 8'h40);
        wr(`AEC_IDX_STP, 8'hF7);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`AEC_IDX_PER_H, 8'hFF);
        rdc(`AEC_IDX_CCR, 8'h00);
        rdc(`AEC_IDX_STP, 8'hFF);
        rdc(`AEC_IDX_CNT_H, 8'h00);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        $display("watchdog expired");
        mismatches++;
        conclude();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_edges();
        t_ovf();
        t_pre();
        t_pwm();
        t_girq();
        t_stby();
        t_rst2();
        conclude();
    end
endmodule
`default_nettype wire
